//--- pkg/afc_pkg.sv
// Purpose: shared constants and carriers for the audio flow control register bank
// Assumes: 16-bit register words at word addresses, one system clock
// Notes: bit positions below are the software-visible layout
package afc_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // word addresses of the bank
  localparam logic [15:0] LOUD_ADDR = 16'h0120;
  localparam logic [15:0] MUTE_ADDR = 16'h0121;
  localparam logic [15:0] FLOW_ADDR = 16'h0122;

  // values after reset
  localparam logic [15:0] LOUD_RST = 16'h0000;
  localparam logic [15:0] MUTE_RST = 16'h0000;
  localparam logic [15:0] FLOW_RST = 16'h8001;

  // loudness register fields
  localparam int LOUD_CUT_HI = 6;
  localparam int LOUD_CUT_LO = 5;
  localparam int LOUD_LVL_HI = 4;
  localparam logic [4:0] LOUD_MAX_DB = 5'h0f;
  localparam logic [6:0] CUT_HZ_0 = 7'h0a;
  localparam logic [6:0] CUT_HZ_1 = 7'h1e;
  localparam logic [6:0] CUT_HZ_2 = 7'h32;
  localparam logic [6:0] CUT_HZ_3 = 7'h46;

  // mute gate bit positions
  localparam int MUTE_TWEETER         = 7;
  localparam int MUTE_WOOFER          = 6;
  localparam int MUTE_AUX3            = 5;
  localparam int MUTE_HP_AUX4         = 4;
  localparam int MUTE_SERIAL_OUT_ZERO = 3;
  localparam int MUTE_SPDIF           = 2;
  localparam int MUTE_AUX1            = 1;

  // flow switch bit positions
  localparam int FLOW_LEVELER  = 14;
  localparam int FLOW_LIPSYNC  = 13;
  localparam int FLOW_MAIN_EQ  = 12;
  localparam int FLOW_BASS     = 11;
  localparam int FLOW_MAIN_LD  = 10;
  localparam int FLOW_MAIN_BP  = 9;
  localparam int FLOW_LIMITER  = 8;
  localparam int FLOW_SPK_EQ   = 7;
  localparam int FLOW_XOVER    = 6;
  localparam int FLOW_TW_SUM   = 5;
  localparam int FLOW_SUB_LPFN = 4;
  localparam int FLOW_HP_EQ    = 3;
  localparam int FLOW_HP_LD    = 2;
  localparam int FLOW_HP_BP    = 1;
  localparam int FLOW_SPATIAL  = 0;

  typedef struct packed {
    logic [6:0] cutoff_hz;
    logic [3:0] boost_db;
  } afc_loud_t;

  typedef struct packed {
    logic tweeter;
    logic woofer;
    logic aux_line_out_three;
    logic headphone_path_one;
    logic serial_audio_out_zero;
    logic spdif;
    logic aux_line_out_one;
  } afc_mute_t;

  typedef struct packed {
    logic auto_volume_leveler;
    logic lipsync_delay;
    logic main_eq;
    logic bass_boost;
    logic main_loudness;
    logic main_beeper_only;
    logic peak_limiters;
    logic speaker_eq;
    logic crossover;
    logic tweeter_sum_woofer;
    logic sub_lowpass;
    logic hp_eq;
    logic hp_loudness;
    logic hp_beeper_only;
    logic spatializer;
  } afc_flow_t;

endpackage

//--- logic/afc_regs.sv
// Purpose: control register bank steering the audio processing engine
// Assumes: serial control front end delivers word accesses on SYS_CLK_IN
// Notes: reads answer one cycle after the request; unmapped reads return zero
//
// How it works
// RL1 - loudness cutoff code 0..3 selects 10, 30, 50 or 70 Hz.
// RL2 - loudness level field gives boost in 1 dB steps, 0 to 15 dB.
// RL3 - host writes zeros into reserved bits of loudness and mute registers.
// RL4 - host writes one into bit 15 of the flow switch register.
// RL5 - each mute bit silences its output at zero, passes audio at one.
// RL6 - mute register reads zero after reset, all outputs silenced.
// RL7 - flow bit 14 enables automatic volume leveling.
// RL8 - flow bit 13 inserts the lip-sync delay.
// RL9 - flow bit 12 enables the seven-band main equalizer.
// RL10 - flow bit 11 enables the bass enhancement stage.
// RL11 - flow bit 10 enables main-channel loudness compensation.
// RL12 - flow bit 9 one gives beeper only, zero mixes beeper and channel.
// RL13 - flow bit 8 enables tweeter and woofer peak limiters.
// RL14 - flow bit 7 enables the eight-band speaker equalizer.
// RL15 - flow bit 6 one activates crossover filters, zero leaves them off.
// RL16 - flow bit 5 one sums woofer into the tweeter output.
// RL17 - flow bit 4 zero keeps subchannel low-pass on, one disables it.
// RL18 - flow bit 3 enables the headphone equalizer.
// RL19 - flow switch register resets to 0x8001.
// RL20 - flow bit 2 enables headphone loudness.
// RL21 - flow bit 1 one gives headphone beeper only.
// RL22 - flow bit 0 enables the spatializer, set after reset.
// RL23 - registers hold the last written value until rewritten or reset.
`timescale 1ns/1ps

module afc_regs #(
  parameter int ADDR_W = afc_pkg::ADDR_W,
  parameter int DATA_W = afc_pkg::DATA_W
) (
  input  wire logic              SYS_CLK_IN,
  input  wire logic              SRST_IN,
  input  wire logic [ADDR_W-1:0] REG_ADDR_IN,
  input  wire logic [DATA_W-1:0] REG_WDATA_IN,
  input  wire logic              REG_WR_IN,
  input  wire logic              REG_RD_IN,
  output logic      [DATA_W-1:0] REG_RDATA_OUT,
  output logic                   REG_RVALID_OUT,
  output afc_pkg::afc_loud_t     LOUD_CFG_OUT,
  output afc_pkg::afc_mute_t     MUTE_GATES_OUT,
  output afc_pkg::afc_flow_t     FLOW_CTRL_OUT
);

  // the host protocol fixes register words at 16 bits
  if (ADDR_W != 16 || DATA_W != 16) begin : g_width_check
    $error("afc_regs serves 16-bit addresses and data only");
  end

  logic [15:0] loud_reg;
  logic [15:0] mute_reg;
  logic [15:0] flow_reg;
  logic [15:0] loud_next;
  logic [15:0] mute_next;
  logic [15:0] flow_next;
  logic [15:0] rdata_reg;
  logic        rvalid_reg;
  afc_pkg::afc_loud_t loud_out_reg;
  afc_pkg::afc_mute_t mute_out_reg;
  afc_pkg::afc_flow_t flow_out_reg;

  function automatic logic [6:0] cutoff_hz(input logic [1:0] code);
    case (code)
      2'h0:    cutoff_hz = afc_pkg::CUT_HZ_0;
      2'h1:    cutoff_hz = afc_pkg::CUT_HZ_1;
      2'h2:    cutoff_hz = afc_pkg::CUT_HZ_2;
      default: cutoff_hz = afc_pkg::CUT_HZ_3;
    endcase
  endfunction

  // codes above 15 dB are undefined; saturate rather than wrap to a small boost
  function automatic logic [3:0] boost_db(input logic [4:0] code);
    if (code > afc_pkg::LOUD_MAX_DB) begin
      boost_db = afc_pkg::LOUD_MAX_DB[3:0];
    end else begin
      boost_db = code[3:0];
    end
  endfunction

  function automatic logic hit(input logic [15:0] addr, input logic [15:0] target);
    hit = (addr == target);
  endfunction

  // the whole word is kept, reserved bits too, so readback matches the write;
  // the host is trusted to write reserved bits as documented
  always_comb begin
    loud_next = loud_reg; // RL23
    mute_next = mute_reg; // RL23
    flow_next = flow_reg; // RL23
    if (REG_WR_IN && hit(REG_ADDR_IN, afc_pkg::LOUD_ADDR)) begin
      loud_next = REG_WDATA_IN; // RL23
    end
    if (REG_WR_IN && hit(REG_ADDR_IN, afc_pkg::MUTE_ADDR)) begin
      mute_next = REG_WDATA_IN; // RL23
    end
    if (REG_WR_IN && hit(REG_ADDR_IN, afc_pkg::FLOW_ADDR)) begin
      flow_next = REG_WDATA_IN; // RL23
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      loud_reg <= afc_pkg::LOUD_RST;
      mute_reg <= afc_pkg::MUTE_RST; // RL6
      flow_reg <= afc_pkg::FLOW_RST; // RL19
    end else begin
      loud_reg <= loud_next;
      mute_reg <= mute_next;
      flow_reg <= flow_next;
    end
  end

  // read port: one-cycle answer, zero for unmapped addresses
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= REG_RD_IN;
      if (!REG_RD_IN) begin
        rdata_reg <= 16'h0000;
      end else if (hit(REG_ADDR_IN, afc_pkg::LOUD_ADDR)) begin
        rdata_reg <= loud_reg;
      end else if (hit(REG_ADDR_IN, afc_pkg::MUTE_ADDR)) begin
        rdata_reg <= mute_reg;
      end else if (hit(REG_ADDR_IN, afc_pkg::FLOW_ADDR)) begin
        rdata_reg <= flow_reg;
      end else begin
        rdata_reg <= 16'h0000;
      end
    end
  end

  // loudness decode, taken from the next value so outputs track the register
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      loud_out_reg <= '{cutoff_hz: afc_pkg::CUT_HZ_0, boost_db: 4'h0};
    end else begin
      loud_out_reg.cutoff_hz <= // RL1
        cutoff_hz(loud_next[afc_pkg::LOUD_CUT_HI:afc_pkg::LOUD_CUT_LO]);
      loud_out_reg.boost_db  <= boost_db(loud_next[afc_pkg::LOUD_LVL_HI:0]); // RL2
    end
  end

  // mute gates: one passes audio, zero silences
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      mute_out_reg <= '0; // RL6
    end else begin
      mute_out_reg.tweeter               <= mute_next[afc_pkg::MUTE_TWEETER]; // RL5
      mute_out_reg.woofer                <= mute_next[afc_pkg::MUTE_WOOFER]; // RL5
      mute_out_reg.aux_line_out_three    <= mute_next[afc_pkg::MUTE_AUX3]; // RL5
      mute_out_reg.headphone_path_one    <= mute_next[afc_pkg::MUTE_HP_AUX4]; // RL5
      mute_out_reg.serial_audio_out_zero <= mute_next[afc_pkg::MUTE_SERIAL_OUT_ZERO]; // RL5
      mute_out_reg.spdif                 <= mute_next[afc_pkg::MUTE_SPDIF]; // RL5
      mute_out_reg.aux_line_out_one      <= mute_next[afc_pkg::MUTE_AUX1]; // RL5
    end
  end

  // flow switches; sub low-pass is the only inverted one
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      flow_out_reg             <= '0;
      flow_out_reg.sub_lowpass <= 1'b1; // RL17
      flow_out_reg.spatializer <= 1'b1; // RL22
    end else begin
      flow_out_reg.auto_volume_leveler <= flow_next[afc_pkg::FLOW_LEVELER]; // RL7
      flow_out_reg.lipsync_delay       <= flow_next[afc_pkg::FLOW_LIPSYNC]; // RL8
      flow_out_reg.main_eq             <= flow_next[afc_pkg::FLOW_MAIN_EQ]; // RL9
      flow_out_reg.bass_boost          <= flow_next[afc_pkg::FLOW_BASS]; // RL10
      flow_out_reg.main_loudness       <= flow_next[afc_pkg::FLOW_MAIN_LD]; // RL11
      flow_out_reg.main_beeper_only    <= flow_next[afc_pkg::FLOW_MAIN_BP]; // RL12
      flow_out_reg.peak_limiters       <= flow_next[afc_pkg::FLOW_LIMITER]; // RL13
      flow_out_reg.speaker_eq          <= flow_next[afc_pkg::FLOW_SPK_EQ]; // RL14
      flow_out_reg.crossover           <= flow_next[afc_pkg::FLOW_XOVER]; // RL15
      flow_out_reg.tweeter_sum_woofer  <= flow_next[afc_pkg::FLOW_TW_SUM]; // RL16
      flow_out_reg.sub_lowpass         <= !flow_next[afc_pkg::FLOW_SUB_LPFN]; // RL17
      flow_out_reg.hp_eq               <= flow_next[afc_pkg::FLOW_HP_EQ]; // RL18
      flow_out_reg.hp_loudness         <= flow_next[afc_pkg::FLOW_HP_LD]; // RL20
      flow_out_reg.hp_beeper_only      <= flow_next[afc_pkg::FLOW_HP_BP]; // RL21
      flow_out_reg.spatializer         <= flow_next[afc_pkg::FLOW_SPATIAL]; // RL22
    end
  end

  assign REG_RDATA_OUT  = rdata_reg;
  assign REG_RVALID_OUT = rvalid_reg;
  assign LOUD_CFG_OUT   = loud_out_reg;
  assign MUTE_GATES_OUT = mute_out_reg;
  assign FLOW_CTRL_OUT  = flow_out_reg;

  // checks
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SRST_IN);

  logic wr_loud;
  logic wr_mute;
  logic wr_flow;
  assign wr_loud = REG_WR_IN && hit(REG_ADDR_IN, afc_pkg::LOUD_ADDR);
  assign wr_mute = REG_WR_IN && hit(REG_ADDR_IN, afc_pkg::MUTE_ADDR);
  assign wr_flow = REG_WR_IN && hit(REG_ADDR_IN, afc_pkg::FLOW_ADDR);

  a_cutoff_map: assert property ( // RL1
    wr_loud |=> LOUD_CFG_OUT.cutoff_hz ==
      ($past(REG_WDATA_IN[6:5]) == 2'h0 ? 7'h0a :
       $past(REG_WDATA_IN[6:5]) == 2'h1 ? 7'h1e :
       $past(REG_WDATA_IN[6:5]) == 2'h2 ? 7'h32 : 7'h46))
    else $error("loudness cutoff does not follow written code");

  a_boost_db_step: assert property ( // RL2
    wr_loud && REG_WDATA_IN[4:0] <= 5'h0f |=> LOUD_CFG_OUT.boost_db == $past(REG_WDATA_IN[3:0]))
    else $error("loudness boost does not follow written level");

  a_mute_gate_map: assert property ( // RL5
    wr_mute |=> MUTE_GATES_OUT == {$past(REG_WDATA_IN[7:1])})
    else $error("mute gates do not follow written word");

  a_mute_after_reset: assert property ( // RL6
    $past(SRST_IN) |-> mute_reg == 16'h0000 && MUTE_GATES_OUT == 7'h00)
    else $error("outputs not silenced after reset");

  a_flow_after_reset: assert property ( // RL19
    $past(SRST_IN) |-> flow_reg == 16'h8001 && FLOW_CTRL_OUT.spatializer
      && FLOW_CTRL_OUT.sub_lowpass && !FLOW_CTRL_OUT.auto_volume_leveler)
    else $error("flow switches wrong after reset");

  a_flow_direct_bits: assert property ( // RL7
    wr_flow |=> {FLOW_CTRL_OUT.auto_volume_leveler, FLOW_CTRL_OUT.lipsync_delay,
      FLOW_CTRL_OUT.main_eq, FLOW_CTRL_OUT.bass_boost, FLOW_CTRL_OUT.main_loudness,
      FLOW_CTRL_OUT.main_beeper_only, FLOW_CTRL_OUT.peak_limiters,
      FLOW_CTRL_OUT.speaker_eq, FLOW_CTRL_OUT.crossover,
      FLOW_CTRL_OUT.tweeter_sum_woofer} == $past(REG_WDATA_IN[14:5]))
    else $error("main flow switches do not follow written word");

  a_sub_lpf_invert: assert property ( // RL17
    wr_flow |=> FLOW_CTRL_OUT.sub_lowpass == !$past(REG_WDATA_IN[4]))
    else $error("subchannel low-pass polarity wrong");

  a_hp_flow_bits: assert property ( // RL18
    wr_flow |=> {FLOW_CTRL_OUT.hp_eq, FLOW_CTRL_OUT.hp_loudness,
      FLOW_CTRL_OUT.hp_beeper_only, FLOW_CTRL_OUT.spatializer} == $past(REG_WDATA_IN[3:0]))
    else $error("headphone flow switches do not follow written word");

  // one check per switch except the leveler and headphone equalizer, so a failure names the stage at fault
  a_lipsync_follows: assert property ( // RL8
    wr_flow |=> FLOW_CTRL_OUT.lipsync_delay == $past(REG_WDATA_IN[13]))
    else $error("lip-sync delay switch does not follow the written bit");

  a_main_eq_follows: assert property ( // RL9
    wr_flow |=> FLOW_CTRL_OUT.main_eq == $past(REG_WDATA_IN[12]))
    else $error("main equalizer switch does not follow the written bit");

  a_bass_follows: assert property ( // RL10
    wr_flow |=> FLOW_CTRL_OUT.bass_boost == $past(REG_WDATA_IN[11]))
    else $error("bass stage switch does not follow the written bit");

  a_main_loud_follows: assert property ( // RL11
    wr_flow |=> FLOW_CTRL_OUT.main_loudness == $past(REG_WDATA_IN[10]))
    else $error("main loudness switch does not follow the written bit");

  a_main_beeper_mix: assert property ( // RL12
    wr_flow |=> FLOW_CTRL_OUT.main_beeper_only == $past(REG_WDATA_IN[9]))
    else $error("main beeper mix does not follow the written bit");

  a_limiter_follows: assert property ( // RL13
    wr_flow |=> FLOW_CTRL_OUT.peak_limiters == $past(REG_WDATA_IN[8]))
    else $error("peak limiter switch does not follow the written bit");

  a_spk_eq_follows: assert property ( // RL14
    wr_flow |=> FLOW_CTRL_OUT.speaker_eq == $past(REG_WDATA_IN[7]))
    else $error("speaker equalizer switch does not follow the written bit");

  a_crossover_follows: assert property ( // RL15
    wr_flow |=> FLOW_CTRL_OUT.crossover == $past(REG_WDATA_IN[6]))
    else $error("crossover switch does not follow the written bit");

  a_tweeter_sum_sel: assert property ( // RL16
    wr_flow |=> FLOW_CTRL_OUT.tweeter_sum_woofer == $past(REG_WDATA_IN[5]))
    else $error("tweeter output select does not follow the written bit");

  a_hp_loud_follows: assert property ( // RL20
    wr_flow |=> FLOW_CTRL_OUT.hp_loudness == $past(REG_WDATA_IN[2]))
    else $error("headphone loudness switch does not follow the written bit");

  a_hp_beeper_mix: assert property ( // RL21
    wr_flow |=> FLOW_CTRL_OUT.hp_beeper_only == $past(REG_WDATA_IN[1]))
    else $error("headphone beeper mix does not follow the written bit");

  a_spatial_follows: assert property ( // RL22
    wr_flow |=> FLOW_CTRL_OUT.spatializer == $past(REG_WDATA_IN[0]))
    else $error("spatializer switch does not follow the written bit");

  a_hold_value: assert property ( // RL23
    !wr_flow && !wr_mute |=> $stable(flow_reg) && $stable(mute_reg)
      && $stable(FLOW_CTRL_OUT) && $stable(MUTE_GATES_OUT))
    else $error("register changed without a write");

  a_read_back: assert property ( // RL23
    wr_flow ##1 !REG_WR_IN ##1 (REG_RD_IN && hit(REG_ADDR_IN, afc_pkg::FLOW_ADDR) && !REG_WR_IN)
      |=> REG_RVALID_OUT && REG_RDATA_OUT == $past(REG_WDATA_IN, 3))
    else $error("readback differs from last write");

  // read port: reads never disturb state, an idle port shows zero
  a_loud_read_back: assert property ( // RL23
    wr_loud ##1 !REG_WR_IN ##1 (REG_RD_IN && hit(REG_ADDR_IN, afc_pkg::LOUD_ADDR) && !REG_WR_IN)
      |=> REG_RVALID_OUT && REG_RDATA_OUT == $past(REG_WDATA_IN, 3))
    else $error("loudness readback differs from last write");

  // saturation is a chosen limit: codes above 15 dB have no defined boost
  a_boost_saturates: assert property ( // RL2
    wr_loud && REG_WDATA_IN[4] |=> LOUD_CFG_OUT.boost_db == 4'hf)
    else $error("loudness boost does not saturate above 15 dB");

  a_loud_hold: assert property ( // RL23
    !wr_loud |=> $stable(loud_reg) && $stable(LOUD_CFG_OUT))
    else $error("loudness register changed without a write");

  a_no_stray_write: assert property ( // RL23
    REG_WR_IN && !wr_loud && !wr_mute && !wr_flow
      |=> $stable(loud_reg) && $stable(mute_reg) && $stable(flow_reg))
    else $error("write to an unmapped address changed a register");

  a_read_answer: assert property ( // RL23
    REG_RD_IN |=> REG_RVALID_OUT)
    else $error("read request not answered in the next cycle");

  a_idle_read_zero: assert property ( // RL23
    !REG_RD_IN |=> !REG_RVALID_OUT && REG_RDATA_OUT == 16'h0000)
    else $error("read port not idle without a request");

  a_unmapped_zero: assert property ( // RL23
    REG_RD_IN && !hit(REG_ADDR_IN, afc_pkg::LOUD_ADDR) && !hit(REG_ADDR_IN, afc_pkg::MUTE_ADDR)
      && !hit(REG_ADDR_IN, afc_pkg::FLOW_ADDR) |=> REG_RDATA_OUT == 16'h0000)
    else $error("unmapped read returned nonzero data");

  a_loud_after_reset: assert property ( // RL1
    $past(SRST_IN) |-> loud_reg == 16'h0000 && LOUD_CFG_OUT.cutoff_hz == 7'h0a)
    else $error("loudness settings wrong after reset");

  c_unmute_all: cover property (wr_mute && REG_WDATA_IN[7:1] == 7'h7f
    ##1 MUTE_GATES_OUT == 7'h7f);
  c_beeper_only: cover property (wr_flow && REG_WDATA_IN[9] ##1 FLOW_CTRL_OUT.main_beeper_only);
  c_max_cutoff: cover property (wr_loud && REG_WDATA_IN[6:0] == 7'h6f
    ##1 LOUD_CFG_OUT.boost_db == 4'hf);
  c_sub_lpf_off: cover property (wr_flow && REG_WDATA_IN[4] ##1 !FLOW_CTRL_OUT.sub_lowpass);
  c_unmapped_rd: cover property (REG_RD_IN && REG_ADDR_IN == 16'h0123 ##1 REG_RVALID_OUT);

endmodule // afc_regs

//--- verification/afc_host_model.sv
// Purpose: host controller model driving the register word port
// Assumes: requests launched 1 ns after the rising clock edge
// Notes: idle address and data show the inverse of the last value, so stale bits never match
`timescale 1ns/1ps

module afc_host_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] rdata_in,
  input  wire logic        rvalid_in,
  output logic      [15:0] addr_out,
  output logic      [15:0] wdata_out,
  output logic             wr_out,
  output logic             rd_out
);
  initial begin
    addr_out  = 16'h0000;
    wdata_out = 16'h0000;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // reserved bits forced to their legal levels whatever the caller passes
  function automatic logic [15:0] legal(input logic [15:0] a, input logic [15:0] d);
    if (a == afc_pkg::LOUD_ADDR) return d & 16'h007f;
    if (a == afc_pkg::MUTE_ADDR) return d & 16'h00fe;
    if (a == afc_pkg::FLOW_ADDR) return d | 16'h8000;
    return d;
  endfunction

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_in);
    #1;
    addr_out  = a;
    wdata_out = legal(a, d);
    wr_out    = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out    = 1'b0;
    addr_out  = ~addr_out;
    wdata_out = ~wdata_out;
  endtask

  // answer is registered on the taking edge and seen 1 ns after it; wait is bounded
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d  = 16'h0000;
    @(posedge clk_in);
    #1;
    addr_out = a;
    rd_out   = 1'b1;
    @(posedge clk_in);
    #1;
    rd_out   = 1'b0;
    addr_out = ~addr_out;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rvalid_in === 1'b1) begin
        d  = rdata_in;
        ok = 1'b1;
      end else begin
        @(posedge clk_in);
        #1;
      end
    end
  endtask
endmodule // afc_host_model

//--- verification/tb.sv
// Purpose: self-checking bench for the audio flow control register bank
// Assumes: host model issues one access at a time
// Notes: expected outputs come from shadow copies of what was written
`timescale 1ns/1ps

module tb;
  logic               sys_clk = 1'b0;
  logic               srst    = 1'b1;
  logic [15:0]        addr;
  logic [15:0]        wdata;
  logic [15:0]        rdata;
  logic               wr;
  logic               rd;
  logic               rvalid;
  afc_pkg::afc_loud_t loud;
  afc_pkg::afc_mute_t mute;
  afc_pkg::afc_flow_t flow;
  int                 err_total  = 0;
  int                 n_compared = 0;
  logic [15:0]        got;
  logic [15:0]        lm = 16'h0000;
  logic [15:0]        mm = 16'h0000;
  logic [15:0]        fm = 16'h8001;
  logic [6:0]         hz [4] = '{7'h0a, 7'h1e, 7'h32, 7'h46};
  logic [4:0]         lv [5] = '{5'h00, 5'h01, 5'h0e, 5'h0f, 5'h1f};

  always #2.5 sys_clk = ~sys_clk;

  afc_regs u_afc_regs (
    .SYS_CLK_IN     (sys_clk),
    .SRST_IN        (srst),
    .REG_ADDR_IN    (addr),
    .REG_WDATA_IN   (wdata),
    .REG_WR_IN      (wr),
    .REG_RD_IN      (rd),
    .REG_RDATA_OUT  (rdata),
    .REG_RVALID_OUT (rvalid),
    .LOUD_CFG_OUT   (loud),
    .MUTE_GATES_OUT (mute),
    .FLOW_CTRL_OUT  (flow)
  );

  afc_host_model u_afc_host_model (
    .clk_in    (sys_clk),
    .rdata_in  (rdata),
    .rvalid_in (rvalid),
    .addr_out  (addr),
    .wdata_out (wdata),
    .wr_out    (wr),
    .rd_out    (rd)
  );

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
    logic ok;
    u_afc_host_model.rd(a, got, ok);
    if (ok !== 1'b1) begin
      err_total++;
      $display("ERROR read answer at %h expected 1 seen 0", a);
      final_report();
    end else begin
      chk("read data", exp, got);
    end
  endtask

  // levels above 15 saturate, as the designer chose
  function automatic logic [3:0] boost_of(input logic [15:0] w);
    return w[4] ? 4'hf : w[3:0];
  endfunction

  // bit 4 is inverted: a zero keeps the sub low-pass running
  function automatic afc_pkg::afc_flow_t flow_of(input logic [15:0] w);
    return {w[14:5], ~w[4], w[3:0]};
  endfunction

  task automatic chk_out();
    chk("loudness cutoff", {9'h000, hz[lm[6:5]]}, {9'h000, loud.cutoff_hz});
    chk("loudness boost", {12'h000, boost_of(lm)}, {12'h000, loud.boost_db});
    chk("mute gates", {9'h000, mm[7:1]}, {9'h000, mute});
    chk("flow switches", {1'b0, flow_of(fm)}, {1'b0, flow});
  endtask

  task automatic put(input logic [15:0] a, input logic [15:0] d);
    u_afc_host_model.wr(a, d);
    if (a == afc_pkg::LOUD_ADDR) lm = d;
    if (a == afc_pkg::MUTE_ADDR) mm = d;
    if (a == afc_pkg::FLOW_ADDR) fm = d;
  endtask

  task automatic chk_all();
    chk_out();
    rdchk(afc_pkg::LOUD_ADDR, lm);
    rdchk(afc_pkg::MUTE_ADDR, mm);
    rdchk(afc_pkg::FLOW_ADDR, fm);
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    chk_all();
    rdchk(16'h0123, 16'h0000);
    $display("test reset values done");
    for (int c = 0; c < 4; c++) begin
      foreach (lv[i]) begin
        put(afc_pkg::LOUD_ADDR, {9'h000, c[1:0], lv[i]});
        chk_all();
      end
    end
    $display("test loudness done");
    for (int b = 1; b < 8; b++) begin
      put(afc_pkg::MUTE_ADDR, 16'h0001 << b);
      chk_all();
    end
    put(afc_pkg::MUTE_ADDR, 16'h00fe);
    chk_all();
    $display("test mute gates done");
    for (int b = 0; b < 15; b++) begin
      put(afc_pkg::FLOW_ADDR, 16'h8000 | (16'h0001 << b));
      rdchk(afc_pkg::FLOW_ADDR, fm);
      chk_all();
    end
    put(afc_pkg::FLOW_ADDR, 16'h8000);
    chk_all();
    $display("test flow switches done");
    put(afc_pkg::LOUD_ADDR, 16'h0055);
    put(afc_pkg::MUTE_ADDR, 16'h00aa);
    put(afc_pkg::FLOW_ADDR, 16'hc0f0);
    put(16'h0123, 16'hffff);
    put(16'h011f, 16'h7fff);
    repeat (20) @(posedge sys_clk);
    #1;
    chk_all();
    $display("test hold done");
    srst = 1'b1;
    @(posedge sys_clk);
    #1;
    srst = 1'b0;
    lm = 16'h0000;
    mm = 16'h0000;
    fm = 16'h8001;
    chk_all();
    $display("test mid-run reset done");
    final_report();
  end
endmodule // tb
